//--- core/sup_pkg.sv
package sup_pkg;
  // Clock period in picoseconds (40 MHz)
  localparam int unsigned CLK_PERIOD_PS = 32'h0000_61A8;
  // Time base tick in nanoseconds (1 ms)
  localparam int unsigned TICK_NS = 32'h000F_4240;
  localparam int unsigned TICK_CYCLES = (TICK_NS * 1000) / CLK_PERIOD_PS;
  // Watchdog period and reset pulse width in ms ticks
  localparam logic [15:0] WD_PERIOD_MS = 16'h0640;
  localparam logic [15:0] RST_PULSE_MS = 16'h00C8;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  typedef struct packed {
    logic supply_low;
    logic manual_low;
    logic kick;
    logic sense_ok;
  } sup_in_t;

  localparam sup_in_t SUP_IN_RESET = '{
    supply_low: 1'b1, manual_low: 1'b0, kick: 1'b0, sense_ok: 1'b0};
endpackage

//--- core/tick_gen.sv
`timescale 1ns/1ps
module tick_gen #(
  parameter int unsigned CYCLES = 40000
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  output logic tick_o
);
  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    tick_d = (cnt_q == LAST);
    cnt_d = tick_d ? '0 : cnt_q + W'(1);
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule // tick_gen

//--- core/supervisor.sv
`timescale 1ns/1ps
// Function
// R1 - Any kick edge restarts watchdog
// R2 - No kick for period means timeout
// R3 - Watchdog timeout gives full reset pulse
// R4 - Expiry high on kicks; off when supply low
// R5 - Low supply asserts reset at once
// R6 - Reset held pulse width after supply recovers
// R7 - Power-fail output follows comparator only
// R8 - Manual reset asserts, then holds pulse width
// R9 - High reset is exact complement
// R10 - Durations counted in time base ticks
module supervisor
  import sup_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter logic [15:0] WD_TICKS = WD_PERIOD_MS,
  parameter logic [15:0] RST_TICKS = RST_PULSE_MS
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic supply_low_i,
  input wire logic manual_rst_n_i,
  input wire logic wd_kick_in_i,
  input wire logic pwr_fail_sense_i,
  output logic sys_rst_n_o,
  output logic sys_rst_o,
  output logic wd_expire_n_o,
  output logic pwr_fail_n_o
);
  sup_in_t raw;
  sup_in_t meta_q;
  sup_in_t sync_q;
  logic kick_prev_q;
  logic tick;

  // Last count of a tick-driven span
  function automatic logic at_last(input logic [15:0] cnt,
                                   input logic [15:0] span);
    return cnt == span - 16'h0001;
  endfunction

  // Advance a span counter by one tick
  function automatic logic [15:0] bump(input logic [15:0] cnt);
    return cnt + 16'h0001;
  endfunction

  assign raw = '{supply_low: supply_low_i, manual_low: !manual_rst_n_i,
                 kick: wd_kick_in_i, sense_ok: pwr_fail_sense_i};

  // Two-stage input synchroniser
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      meta_q <= SUP_IN_RESET;
      sync_q <= SUP_IN_RESET;
      kick_prev_q <= 1'b0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
      kick_prev_q <= sync_q.kick;
    end
  end

  tick_gen #(.CYCLES(TICK_CYC)) u_tick ( // R10
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .tick_o(tick)
  );

  // Watchdog
  logic kick_edge;
  logic wd_off;
  logic wd_fire;
  logic [15:0] wd_cnt_q;
  logic [15:0] wd_cnt_d;
  logic wd_exp_n_q;
  logic wd_exp_n_d;
  logic rst_act_q;

  always_comb begin
    kick_edge = sync_q.kick ^ kick_prev_q; // R1
    wd_off = sync_q.supply_low || rst_act_q;
    wd_fire = !wd_off && !kick_edge && tick && at_last(wd_cnt_q, WD_TICKS); // R2
    wd_cnt_d = wd_cnt_q;
    wd_exp_n_d = wd_exp_n_q;
    if (wd_off || kick_edge) begin
      wd_cnt_d = CNT_RESET; // R1
    end else if (wd_fire) begin
      wd_cnt_d = CNT_RESET;
    end else if (tick) begin
      wd_cnt_d = bump(wd_cnt_q);
    end
    if (sync_q.supply_low || kick_edge) begin
      wd_exp_n_d = 1'b1; // R4
    end else if (wd_fire) begin
      wd_exp_n_d = 1'b0; // R2
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wd_cnt_q <= CNT_RESET;
      wd_exp_n_q <= 1'b1;
    end else begin
      wd_cnt_q <= wd_cnt_d;
      wd_exp_n_q <= wd_exp_n_d;
    end
  end

  // Reset generator
  logic rst_src;
  logic rst_act_d;
  logic [15:0] rst_cnt_q;
  logic [15:0] rst_cnt_d;
  logic pf_n_q;
  logic pf_n_d;
  logic rst_hi_q;
  logic rst_n_q;

  always_comb begin
    rst_src = sync_q.supply_low || sync_q.manual_low || wd_fire; // R5 R8 R3
    rst_act_d = rst_act_q;
    rst_cnt_d = rst_cnt_q;
    if (rst_src) begin
      rst_act_d = 1'b1;
      rst_cnt_d = CNT_RESET;
    end else if (rst_act_q && tick) begin
      if (at_last(rst_cnt_q, RST_TICKS)) begin
        rst_act_d = 1'b0; // R6
        rst_cnt_d = CNT_RESET;
      end else begin
        rst_cnt_d = bump(rst_cnt_q);
      end
    end
    pf_n_d = sync_q.sense_ok; // R7
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      rst_act_q <= 1'b1;
      rst_hi_q <= 1'b1;
      rst_n_q <= 1'b0;
      rst_cnt_q <= CNT_RESET;
      pf_n_q <= 1'b0;
    end else begin
      rst_act_q <= rst_act_d;
      rst_hi_q <= rst_act_d; // R9
      rst_n_q <= !rst_act_d; // R5
      rst_cnt_q <= rst_cnt_d;
      pf_n_q <= pf_n_d;
    end
  end

  // Cycles from the last reset source, for the pulse width check
  localparam logic [31:0] MIN_PULSE =
    32'((32'(RST_TICKS) - 32'h0000_0001) * TICK_CYC + 32'h0000_0001);
  localparam logic [31:0] MAX_PULSE = 32'(32'(RST_TICKS) * TICK_CYC);
  logic [31:0] quiet_q;
  logic [31:0] quiet_d;

  always_comb begin
    quiet_d = quiet_q;
    if (rst_src) begin
      quiet_d = '0;
    end else if (rst_act_q) begin
      quiet_d = quiet_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      quiet_q <= '0;
    end else begin
      quiet_q <= quiet_d;
    end
  end

  assign sys_rst_n_o = rst_n_q;
  assign sys_rst_o = rst_hi_q;
  assign wd_expire_n_o = wd_exp_n_q;
  assign pwr_fail_n_o = pf_n_q;

  // Checks
  a_rst_complement: assert property (@(posedge clock_i) disable iff (!nrst_i)
    sys_rst_o == !sys_rst_n_o) else $error("reset outputs differ"); // R9
  a_supply_low_rst: assert property (@(posedge clock_i) disable iff (!nrst_i)
    sync_q.supply_low |=> !sys_rst_n_o) else $error("no supply reset"); // R5
  a_manual_rst: assert property (@(posedge clock_i) disable iff (!nrst_i)
    sync_q.manual_low |=> !sys_rst_n_o) else $error("no manual reset"); // R8
  a_pf_follows: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ##1 pwr_fail_n_o == $past(sync_q.sense_ok))
    else $error("power fail mismatch"); // R7
  a_wd_disabled: assert property (@(posedge clock_i) disable iff (!nrst_i)
    sync_q.supply_low |=> wd_expire_n_o && wd_cnt_q == CNT_RESET)
    else $error("watchdog active at low supply"); // R4
  a_kick_restart: assert property (@(posedge clock_i) disable iff (!nrst_i)
    kick_edge |=> wd_cnt_q == CNT_RESET && wd_expire_n_o)
    else $error("kick did not restart"); // R1
  a_wd_timeout: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (!wd_off && !kick_edge && tick && wd_cnt_q == WD_TICKS - 16'h0001)
    |=> !wd_expire_n_o && !sys_rst_n_o) else $error("no timeout"); // R2
  a_timeout_rst: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wd_fire |=> !sys_rst_n_o && rst_cnt_q == CNT_RESET)
    else $error("timeout reset missing"); // R3
  a_rst_release: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(sys_rst_n_o) |-> $past(rst_cnt_q) == RST_TICKS - 16'h0001
    && $past(tick)) else $error("early reset release"); // R6
  a_pulse_width: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(sys_rst_n_o) |-> quiet_q >= MIN_PULSE && quiet_q <= MAX_PULSE)
    else $error("reset pulse width out of range"); // R6
  a_expire_holds: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !wd_expire_n_o && !kick_edge && !sync_q.supply_low |=> !wd_expire_n_o)
    else $error("expiry released without kick"); // R2
  a_wd_quiet_rst: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !sys_rst_n_o |-> !wd_fire)
    else $error("watchdog fired in reset"); // R3
  a_cnt_bounds: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wd_cnt_q < WD_TICKS && rst_cnt_q < RST_TICKS)
    else $error("counter past its span"); // R10
  c_wd_fire: cover property (@(posedge clock_i) disable iff (!nrst_i)
    wd_fire);
  c_rst_release: cover property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(sys_rst_n_o));
  c_manual: cover property (@(posedge clock_i) disable iff (!nrst_i)
    $fell(sync_q.manual_low) && !sync_q.supply_low);
  c_kick_seen: cover property (@(posedge clock_i) disable iff (!nrst_i)
    kick_edge && !wd_off);
  c_supply_dip: cover property (@(posedge clock_i) disable iff (!nrst_i)
    $rose(sync_q.supply_low));
endmodule // supervisor

//--- verif/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic clock_i,
  input wire logic sys_rst_n_i,
  input wire logic kick_en_i,
  output logic wd_kick_o
);
  logic [4:0] gap_q = 5'h00;
  initial wd_kick_o = 1'b0;
  // Host toggles its kick line every 20 cycles, silent while held in reset
  always @(posedge clock_i) begin
    if (!sys_rst_n_i || !kick_en_i) begin
      gap_q <= 5'h00;
    end else if (gap_q == 5'h13) begin
      gap_q <= 5'h00;
      wd_kick_o <= ~wd_kick_o;
    end else begin
      gap_q <= gap_q + 5'h01;
    end
  end
endmodule // host_model

//--- verif/supervisor_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t mismatch", $time); end end
module supervisor_test;
  import sup_pkg::*;
  localparam int unsigned TC = 4;
  localparam logic [15:0] RT = 16'h0004;
  localparam logic [15:0] WT = 16'h0010;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic supply_low_i = 1'b0;
  logic manual_rst_n_i = 1'b1;
  logic pwr_fail_sense_i = 1'b1;
  logic kick_en = 1'b0;
  logic kick, sys_rst_n_o, sys_rst_o, wd_expire_n_o, pwr_fail_n_o;
  int err_count = 0;
  int checks = 0;
  always #12.5 clock_i = ~clock_i;
  supervisor #(.TICK_CYC(TC), .WD_TICKS(WT), .RST_TICKS(RT)) u_supervisor (
    .clock_i(clock_i), .nrst_i(nrst_i), .supply_low_i(supply_low_i),
    .manual_rst_n_i(manual_rst_n_i), .wd_kick_in_i(kick),
    .pwr_fail_sense_i(pwr_fail_sense_i), .sys_rst_n_o(sys_rst_n_o),
    .sys_rst_o(sys_rst_o), .wd_expire_n_o(wd_expire_n_o),
    .pwr_fail_n_o(pwr_fail_n_o));
  host_model u_host_model (.clock_i(clock_i), .sys_rst_n_i(sys_rst_n_o),
    .kick_en_i(kick_en), .wd_kick_o(kick));
  task automatic close_out;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // Reset must stay low at least (RT-1)*TC cycles and at most RT*TC+4 cycles
  task automatic await_release;
    int n;
    n = 0;
    while (sys_rst_n_o !== 1'b1 && n < 500) begin
      cyc(1);
      n++;
      `CHK(sys_rst_o, ~sys_rst_n_o)
    end
    `CHK(n >= int'(RT - 1) * TC && n <= int'(RT) * TC + 4, 1'b1)
  endtask
  task automatic t_supply;
    @(posedge clock_i) supply_low_i <= 1'b1;
    cyc(3);
    `CHK(sys_rst_n_o, 1'b0)
    `CHK(wd_expire_n_o, 1'b1)
    @(posedge clock_i) pwr_fail_sense_i <= 1'b0;
    cyc(3);
    `CHK(pwr_fail_n_o, 1'b0)
    @(posedge clock_i) pwr_fail_sense_i <= 1'b1;
    cyc(3);
    `CHK(pwr_fail_n_o, 1'b1)
    cyc(int'(WT) * TC + 8);
    `CHK({wd_expire_n_o, sys_rst_n_o}, 2'b10)
    @(posedge clock_i) supply_low_i <= 1'b0;
    await_release();
  endtask
  task automatic t_manual;
    @(posedge clock_i) manual_rst_n_i <= 1'b0;
    cyc(3);
    `CHK(sys_rst_n_o, 1'b0)
    `CHK(pwr_fail_n_o, 1'b1)
    @(posedge clock_i) manual_rst_n_i <= 1'b1;
    await_release();
  endtask
  task automatic t_kick;
    @(posedge clock_i) kick_en <= 1'b1;
    repeat (200) begin
      cyc(1);
      `CHK({wd_expire_n_o, sys_rst_n_o}, 2'b11)
    end
  endtask
  task automatic t_timeout;
    int n;
    n = 0;
    @(kick);
    @(posedge clock_i) kick_en <= 1'b0;
    while (wd_expire_n_o === 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    `CHK(n >= int'(WT - 1) * TC, 1'b1)
    `CHK(n <= int'(WT) * TC + 8, 1'b1)
    `CHK({wd_expire_n_o, sys_rst_n_o}, 2'b00)
    await_release();
    `CHK(wd_expire_n_o, 1'b0)
    @(posedge clock_i) kick_en <= 1'b1;
    cyc(30);
    `CHK(wd_expire_n_o, 1'b1)
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    nrst_i <= 1'b1;
    #1;
    `CHK({sys_rst_n_o, sys_rst_o}, 2'b01)
    `CHK({wd_expire_n_o, pwr_fail_n_o}, 2'b10)
    await_release();
    t_supply();
    t_manual();
    t_kick();
    t_timeout();
    close_out();
  end
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule // supervisor_test
